/* design/mra_region_regs.sv */
// Functional notes
// - base and attribute act on selected region
// - base write, valid clear: keep selector
// - base write, valid set: load selector first
// - valid bit always reads zero
// - base low bits read current selector
// - base bits 31:N read back, N-1:5 read zero
// - 32 byte region: address bits 31:5
// - 4 GB region: no address, base zero
// - size field gives 2^(size+1) bytes, at least 32
// - size 31 means 4 GB region
// - execute_never bit forbids instruction fetches
// - permission codes 000 to 011 decoded
// - permission codes 100 to 111 decoded
// - non-cacheable: strongly-ordered or device, shareable
// - cacheable: normal, through or back, shareable from s bit
// - subregion_disable bit disables its subregion
// - enable bit zero on reset
// - reserved attribute bits always zero
// - permission failure raises severe fault exception
// - selector addresses eight regions only
// - uncovered address faults without background map
`include "mra_consts.svh"
module mra_region_regs
    import mra_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,

    // register access port, system control space addresses
    input  wire logic [31:0] reg_addr,
    input  wire logic [3:0]  reg_be,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [31:0] reg_wdata,
    output logic      [31:0] reg_rdata,
    output logic             reg_rvalid,

    // protection control levels
    input  wire logic        mpu_enable,
    input  wire logic        background_enable,

    // access presented by the load, store and fetch path
    input  wire logic        acc_valid,
    input  wire logic [31:0] acc_addr,
    input  wire logic        acc_priv,
    input  wire logic        acc_write,
    input  wire logic        acc_fetch,

    // check result
    output logic             acc_done,
    output logic             acc_fault,
    output logic             acc_miss_fault,
    output logic             acc_hit,
    output logic      [2:0]  acc_region,
    output mra_mem_e         acc_mem_type,
    output logic             acc_shareable,
    output logic             acc_write_back,
    output logic             severe_fault_exception
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        mra_region_t rgn;
        logic [2:0]  sel;
        logic [31:0] rdata;
        logic        rvalid;
        logic        done;
        logic        fault;
        logic        miss;
        logic        hit;
        logic [2:0]  region;
        mra_mem_e    mem_type;
        logic        shareable;
        logic        write_back;
        logic        severe;
    } mra_regs_s;

    mra_regs_s q;
    mra_regs_s d;

    localparam int unsigned NR = `MRA_NUM_REGIONS;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------

    // byte-lane merge for partial writes (halfword writes are common)
    function automatic logic [31:0] merge_be(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old_w;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        merge_be = r;
    endfunction

    // attribute word; reserved positions come out as zero
    function automatic logic [31:0] attr_word(input mra_region_s r);
        logic [31:0] w;
        w = 32'h00000000;
        w[`MRA_ASR_XN] = r.xn;
        w[`MRA_ASR_AP_LO +: 3] = r.ap;
        w[`MRA_ASR_S] = r.s;
        w[`MRA_ASR_C] = r.c;
        w[`MRA_ASR_B] = r.b;
        w[`MRA_ASR_SRD_LO +: 8] = r.subregion_disable;
        w[`MRA_ASR_SIZE_LO +: 5] = r.size;
        w[`MRA_ASR_EN] = r.en;
        attr_word = w;
    endfunction

    // base address bits as stored, masked to 31:n for reads
    function automatic logic [31:0] base_word(input mra_region_s r);
        base_word = {r.base, 5'h00} & mra_base_mask(r.size);
    endfunction

    // highest-numbered hit wins
    function automatic logic [2:0] pick_region(input logic [NR-1:0] h);
        logic [2:0] w;
        w = 3'h0;
        for (int i = 0; i < NR; i++) begin
            if (h[i]) begin
                w = i[2:0];
            end
        end
        pick_region = w;
    endfunction

    // ------------------------------------------------------------------
    // per-region address match
    // ------------------------------------------------------------------
    logic [NR-1:0] hits;

    for (genvar g = 0; g < NR; g++) begin : g_match
        mra_match_if m_if ();

        // every region compares against the same access address
        assign m_if.addr = acc_addr;
        assign m_if.base = q.rgn[g].base;
        assign m_if.size = q.rgn[g].size;
        assign m_if.subregion_disable  = q.rgn[g].subregion_disable;
        assign m_if.en   = q.rgn[g].en;
        assign hits[g]   = m_if.hit;

        mra_region_match u_match (
            .bus (m_if)
        );
    end

    // ------------------------------------------------------------------
    // permission decode for the winning region
    // ------------------------------------------------------------------
    logic [2:0]  win;
    mra_perm_if  p_if ();

    assign win        = pick_region(hits);
    assign p_if.ap    = q.rgn[win].ap;
    assign p_if.xn    = q.rgn[win].xn;
    assign p_if.c     = q.rgn[win].c;
    assign p_if.b     = q.rgn[win].b;
    assign p_if.s     = q.rgn[win].s;
    assign p_if.priv  = acc_priv;
    assign p_if.write = acc_write;
    assign p_if.fetch = acc_fetch;

    mra_perm_check u_perm (
        .bus (p_if)
    );

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [2:0]  tgt;
        logic [31:0] w;
        tgt = q.sel;
        w   = 32'h00000000;
        d   = q;
        d.rvalid = 1'b0;
        d.done   = 1'b0;
        d.severe = 1'b0;

        // selector write; only eight regions, upper bits dropped
        if (reg_wr && reg_addr == `MRA_ADDR_SELECTOR && reg_be[0]) begin
            d.sel = reg_wdata[2:0];
        end

        // base write, optionally retargeting the selector first
        if (reg_wr && reg_addr == `MRA_ADDR_BASE) begin
            if (reg_be[0] && reg_wdata[`MRA_BAR_VALID]) begin
                tgt   = reg_wdata[2:0];
                d.sel = reg_wdata[2:0];
            end else begin
                tgt = q.sel;
            end
            w = merge_be({q.rgn[tgt].base, 5'h00}, reg_wdata, reg_be);
            d.rgn[tgt].base = w[31:`MRA_BAR_ADDR_LO];
        end

        // attribute write to the selected region
        if (reg_wr && reg_addr == `MRA_ADDR_ATTR) begin
            w = merge_be(attr_word(q.rgn[q.sel]), reg_wdata, reg_be);
            // only defined fields are stored; the rest stays zero
            d.rgn[q.sel].xn   = w[`MRA_ASR_XN];
            d.rgn[q.sel].ap   = w[`MRA_ASR_AP_LO +: 3];
            d.rgn[q.sel].s    = w[`MRA_ASR_S];
            d.rgn[q.sel].c    = w[`MRA_ASR_C];
            d.rgn[q.sel].b    = w[`MRA_ASR_B];
            d.rgn[q.sel].subregion_disable  = w[`MRA_ASR_SRD_LO +: 8];
            d.rgn[q.sel].size = w[`MRA_ASR_SIZE_LO +: 5];
            d.rgn[q.sel].en   = w[`MRA_ASR_EN];
        end

        // reads return the state before any same-cycle write
        if (reg_rd) begin
            d.rvalid = 1'b1;
            if (reg_addr == `MRA_ADDR_SELECTOR) begin
                d.rdata = {29'h00000000, q.sel};
            end else if (reg_addr == `MRA_ADDR_BASE) begin
                // valid reads zero, region bits show the selector
                d.rdata = base_word(q.rgn[q.sel]) | {28'h0000000, 1'b0, q.sel};
            end else if (reg_addr == `MRA_ADDR_ATTR) begin
                d.rdata = attr_word(q.rgn[q.sel]);
            end else begin
                d.rdata = `MRA_RESET_RDATA;
            end
        end

        // access check, answered one cycle after acc_valid
        if (acc_valid) begin
            d.done = 1'b1;
            if (!mpu_enable) begin
                // protection off: default map, nothing faults
                d.fault      = 1'b0;
                d.miss       = 1'b0;
                d.hit        = 1'b0;
                d.region     = 3'h0;
                d.mem_type   = MRA_MEM_NORMAL_WT;
                d.shareable  = 1'b0;
                d.write_back = 1'b0;
            end else if (|hits) begin
                d.hit        = 1'b1;
                d.region     = win;
                d.fault      = !p_if.allowed;
                d.miss       = 1'b0;
                d.mem_type   = p_if.mem_type;
                d.shareable  = p_if.shareable;
                d.write_back = p_if.write_back;
            end else begin
                // background map only serves privileged software
                d.hit        = 1'b0;
                d.region     = 3'h0;
                d.fault      = !(background_enable && acc_priv);
                d.miss       = !(background_enable && acc_priv);
                d.mem_type   = MRA_MEM_NORMAL_WT;
                d.shareable  = 1'b0;
                d.write_back = 1'b0;
            end
            d.severe = d.fault;
        end
    end

    // ------------------------------------------------------------------
    // state register; all region enables clear on reset
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // outputs, all from flip-flops
    // ------------------------------------------------------------------
    assign reg_rdata              = q.rdata;
    assign reg_rvalid             = q.rvalid;
    assign acc_done               = q.done;
    assign acc_fault              = q.fault;
    assign acc_miss_fault         = q.miss;
    assign acc_hit                = q.hit;
    assign acc_region             = q.region;
    assign acc_mem_type           = q.mem_type;
    assign acc_shareable          = q.shareable;
    assign acc_write_back         = q.write_back;
    assign severe_fault_exception = q.severe;

endmodule

/* shared/mra_consts.svh */
`ifndef MRA_CONSTS_SVH
`define MRA_CONSTS_SVH

// ----------------------------------------------------------------------
// region count and register addresses
// ----------------------------------------------------------------------
`define MRA_NUM_REGIONS    8
`define MRA_ADDR_SELECTOR  32'hE000ED98
`define MRA_ADDR_BASE      32'hE000ED9C
`define MRA_ADDR_ATTR      32'hE000EDA0

// ----------------------------------------------------------------------
// base register fields
// ----------------------------------------------------------------------
`define MRA_BAR_VALID      4
`define MRA_BAR_ADDR_LO    5

// ----------------------------------------------------------------------
// attribute/size register fields
// ----------------------------------------------------------------------
`define MRA_ASR_XN         28
`define MRA_ASR_AP_LO      24
`define MRA_ASR_S          18
`define MRA_ASR_C          17
`define MRA_ASR_B          16
`define MRA_ASR_SRD_LO     8
`define MRA_ASR_SIZE_LO    1
`define MRA_ASR_EN         0

// ----------------------------------------------------------------------
// size limits and reset values
// ----------------------------------------------------------------------
`define MRA_SIZE_MIN_SRD   5'h07
`define MRA_SIZE_MIN_ADDR  5'h04
`define MRA_N_MIN          6'h05
`define MRA_RESET_RDATA    32'h00000000

`endif

/* shared/mra_pkg.sv */
`include "mra_consts.svh"

package mra_pkg;

    // ------------------------------------------------------------------
    // memory type encoding reported with each checked access
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MRA_MEM_STRONG    = 2'b00,
        MRA_MEM_DEVICE    = 2'b01,
        MRA_MEM_NORMAL_WT = 2'b10,
        MRA_MEM_NORMAL_WB = 2'b11
    } mra_mem_e;

    // ------------------------------------------------------------------
    // per-region programmed state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        xn;
        logic [2:0]  ap;
        logic        s;
        logic        c;
        logic        b;
        logic [7:0]  subregion_disable;
        logic [4:0]  size;
        logic        en;
        logic [26:0] base;
    } mra_region_s;

    typedef mra_region_s [`MRA_NUM_REGIONS-1:0] mra_region_t;

    // exponent n of the region: size+1, never below the 32 byte floor
    function automatic logic [5:0] mra_exp(input logic [4:0] size);
        mra_exp = (size < `MRA_SIZE_MIN_ADDR) ? `MRA_N_MIN : ({1'b0, size} + 6'h01);
    endfunction

    // mask of the base address bits 31:n; empty for a 4 GB region
    function automatic logic [31:0] mra_base_mask(input logic [4:0] size);
        logic [32:0] low;
        low = (33'h000000001 << mra_exp(size)) - 33'h000000001;
        mra_base_mask = ~low[31:0];
    endfunction

endpackage

/* shared/mra_if.sv */
// ----------------------------------------------------------------------
// address match carrier for one region
// ----------------------------------------------------------------------
interface mra_match_if;
    logic [31:0] addr;
    logic [26:0] base;
    logic [4:0]  size;
    logic [7:0]  subregion_disable;
    logic        en;
    logic        hit;

    modport owner   (output addr, base, size, subregion_disable, en, input hit);
    modport matcher (input addr, base, size, subregion_disable, en, output hit);
endinterface

// ----------------------------------------------------------------------
// permission and attribute decode carrier
// ----------------------------------------------------------------------
interface mra_perm_if;
    import mra_pkg::*;
    logic [2:0] ap;
    logic       xn;
    logic       c;
    logic       b;
    logic       s;
    logic       priv;
    logic       write;
    logic       fetch;
    logic       allowed;
    mra_mem_e   mem_type;
    logic       shareable;
    logic       write_back;

    modport owner   (output ap, xn, c, b, s, priv, write, fetch,
                     input allowed, mem_type, shareable, write_back);
    modport decoder (input ap, xn, c, b, s, priv, write, fetch,
                     output allowed, mem_type, shareable, write_back);
endinterface

/* design/mra_region_match.sv */
`include "mra_consts.svh"
module mra_region_match
    import mra_pkg::*;
(
    // region fields and access address
    mra_match_if.matcher bus
);

    logic [31:0] mask;
    logic [5:0]  n;
    logic [32:0] shifted;
    logic [2:0]  sub_idx;
    logic        sub_ok;

    // address compare against the base, size-dependent mask
    always_comb begin
        mask    = mra_base_mask(bus.size);
        n       = mra_exp(bus.size);
        shifted = {1'b0, bus.addr} >> (n - 6'h03);
        sub_idx = shifted[2:0];
        // subregions exist only from 256 bytes upward
        sub_ok  = (bus.size < `MRA_SIZE_MIN_SRD) || !bus.subregion_disable[sub_idx];
        bus.hit = bus.en && sub_ok &&
                  ((bus.addr & mask) == ({bus.base, 5'h00} & mask));
    end

endmodule

/* design/mra_perm_check.sv */
module mra_perm_check
    import mra_pkg::*;
(
    // attributes of the winning region and access kind
    mra_perm_if.decoder bus
);

    logic rd_ok;
    logic wr_ok;

    // permission table; reserved code 100 is treated as no access
    always_comb begin
        rd_ok = 1'b0;
        wr_ok = 1'b0;
        unique case (bus.ap)
            3'h0: begin rd_ok = 1'b0;     wr_ok = 1'b0;     end
            3'h1: begin rd_ok = bus.priv; wr_ok = bus.priv; end
            3'h2: begin rd_ok = 1'b1;     wr_ok = bus.priv; end
            3'h3: begin rd_ok = 1'b1;     wr_ok = 1'b1;     end
            3'h4: begin rd_ok = 1'b0;     wr_ok = 1'b0;     end
            3'h5: begin rd_ok = bus.priv; wr_ok = 1'b0;     end
            3'h6: begin rd_ok = 1'b1;     wr_ok = 1'b0;     end
            3'h7: begin rd_ok = 1'b1;     wr_ok = 1'b0;     end
        endcase
        // fetches need read rights and a clear execute_never
        if (bus.fetch) begin
            bus.allowed = rd_ok && !bus.xn;
        end else begin
            bus.allowed = bus.write ? wr_ok : rd_ok;
        end
    end

    // memory type: shareable ignored for the ordered types
    always_comb begin
        if (!bus.c) begin
            bus.mem_type   = bus.b ? MRA_MEM_DEVICE : MRA_MEM_STRONG;
            bus.shareable  = 1'b1;
            bus.write_back = 1'b0;
        end else begin
            bus.mem_type   = bus.b ? MRA_MEM_NORMAL_WB : MRA_MEM_NORMAL_WT;
            bus.shareable  = bus.s;
            bus.write_back = bus.b;
        end
    end

endmodule

/* test/mra_region_regs_asserts.sv */
`include "mra_consts.svh"

// ------------------
// port-level checks
// ------------------
module mra_region_regs_chk
    import mra_pkg::*;
(
    // clock and reset
    input logic        clk,
    input logic        rstn,
    // register port
    input logic [31:0] reg_addr,
    input logic [3:0]  reg_be,
    input logic        reg_wr,
    input logic        reg_rd,
    input logic [31:0] reg_wdata,
    input logic [31:0] reg_rdata,
    input logic        reg_rvalid,
    // protection levels
    input logic        mpu_enable,
    input logic        background_enable,
    // access request
    input logic        acc_valid,
    input logic [31:0] acc_addr,
    input logic        acc_priv,
    input logic        acc_write,
    input logic        acc_fetch,
    // access result
    input logic        acc_done,
    input logic        acc_fault,
    input logic        acc_miss_fault,
    input logic        acc_hit,
    input logic [2:0]  acc_region,
    input mra_mem_e    acc_mem_type,
    input logic        acc_shareable,
    input logic        acc_write_back,
    input logic        severe_fault_exception
);
    // one clock domain, so clocking and disable are shared
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_valid_reads_zero: assert property (
        reg_rvalid && $past(reg_addr) == `MRA_ADDR_BASE |-> reg_rdata[4:3] == 2'b00)
        else $error("base read shows valid flag");
    a_region_reads_sel: assert property (
        (reg_wr && reg_addr == `MRA_ADDR_BASE && reg_be[0] && reg_wdata[4] && !reg_wdata[3])
        ##1 (reg_rd && !reg_wr && reg_addr == `MRA_ADDR_BASE)
        |=> reg_rdata[2:0] == $past(reg_wdata[2:0], 2))
        else $error("region field not taken from base write");
    a_attr_reserved_zero: assert property (
        reg_rvalid && $past(reg_addr) == `MRA_ADDR_ATTR |-> (reg_rdata & 32'hE8F800C0) == 0)
        else $error("reserved attribute bits read nonzero");
    a_fault_raises_exc: assert property (
        acc_done |-> severe_fault_exception == acc_fault)
        else $error("exception does not follow fault");
    a_exc_only_done: assert property (
        !acc_done |-> !severe_fault_exception)
        else $error("exception without checked access");
    a_miss_no_hit: assert property (
        acc_miss_fault |-> acc_fault && !acc_hit && acc_region == 3'h0)
        else $error("miss fault with a hit");
    a_miss_cause: assert property (
        (acc_valid && mpu_enable && !(background_enable && acc_priv)) ##1 (acc_done && !acc_hit)
        |-> acc_miss_fault)
        else $error("uncovered access not faulted");
    a_strong_share: assert property (
        acc_done && acc_hit && !acc_mem_type[1] |-> acc_shareable && !acc_write_back)
        else $error("uncached region not shareable");

    // main scenarios reached
    c_severe: cover property (severe_fault_exception);
    c_miss: cover property (acc_miss_fault);
    c_top_region: cover property (acc_done && acc_hit && acc_region == 3'h7);
endmodule

bind mra_region_regs mra_region_regs_chk u_chk (.*);

/* test/mra_cpu_model.sv */
// ------------------------
// load, store, fetch path
// ------------------------
module mra_cpu_model (
    // clock
    input  logic        clk,
    // access request
    output logic        acc_valid,
    output logic [31:0] acc_addr,
    output logic        acc_priv,
    output logic        acc_write,
    output logic        acc_fetch,
    // protection levels from the core control
    output logic        mpu_enable,
    output logic        background_enable
);
    timeunit 1ns;
    timeprecision 1ns;

    // idle at time zero
    initial begin
        acc_valid = 1'b0;
        acc_addr = 32'h0;
        {acc_priv, acc_write, acc_fetch, mpu_enable, background_enable} = 5'h00;
    end

    // one access, taken at the next rising edge
    task automatic issue(input logic [31:0] a, input logic [4:0] k);
        acc_valid = 1'b1;
        acc_addr = a;
        {acc_priv, acc_write, acc_fetch, mpu_enable, background_enable} = k;
        @(negedge clk);
    endtask

    // stall: address inverted so stale values never pass
    task automatic idle();
        acc_valid = 1'b0;
        acc_addr = ~acc_addr;
        @(negedge clk);
    endtask
endmodule

/* test/mra_region_regs_test.sv */
`include "mra_consts.svh"

module mra_region_regs_test
    import mra_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk, rstn, reg_wr, reg_rd, reg_rvalid, acc_valid, acc_priv, acc_write;
    logic        acc_fetch, mpu_enable, background_enable, acc_done, acc_fault, acc_miss_fault;
    logic        acc_hit, acc_shareable, acc_write_back, severe_fault_exception;
    logic [31:0] reg_addr, reg_wdata, reg_rdata, acc_addr;
    logic [3:0]  reg_be;
    logic [2:0]  acc_region;
    mra_mem_e    acc_mem_type;
    int          failures = 0;
    int          checks_done = 0;
    int          cycles = 0;
    int unsigned base_m[8], attr_m[8], sel_m;

    mra_region_regs DUT (.*);
    mra_cpu_model u_cpu (.*);

    // 50 ns clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // hang guard, far above the run length
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            failures++;
            test_done();
        end
    end

    // ----------------
    // reference model
    // ----------------
    function automatic int unsigned nexp(int r);
        int unsigned sz = (attr_m[r] >> 1) & 31;
        return (sz < 4) ? 5 : sz + 1;
    endfunction

    // a 4 GB region has no address bits at all
    function automatic int unsigned amask(int r);
        return (nexp(r) == 32) ? 0 : ~((32'h1 << nexp(r)) - 1);
    endfunction

    // {done, fault, miss, hit, region, type, shareable, write_back}
    function automatic logic [10:0] expect_acc(input logic [31:0] a, input logic [4:0] k);
        int hit;
        int unsigned n, sub, ap;
        logic [31:0] at;
        logic rok, wok, ok;
        hit = -1;
        if (!k[1]) return 11'h408;
        for (int r = 0; r < 8; r++) begin
            n = nexp(r);
            sub = (n == 32) ? a >> 29 : (a >> (n - 3)) & 7;
            at = attr_m[r];
            if (at[0] && ((a ^ base_m[r]) & amask(r)) == 0 && !(at[5:1] >= 7 && at[8 + sub]))
                hit = r;
        end
        if (hit < 0) return {1'b1, {2{!(k[0] && k[4])}}, 1'b0, 3'h0, 2'b10, 2'b00};
        at = attr_m[hit];
        ap = at[26:24];
        rok = k[4] ? (ap != 0 && ap != 4) : (ap == 2 || ap == 3 || ap >= 6);
        wok = k[4] ? (ap >= 1 && ap <= 3) : (ap == 3);
        ok = k[2] ? (rok && !at[28]) : (k[3] ? wok : rok);
        return {1'b1, !ok, 1'b0, 1'b1, 3'(hit), at[17], at[16], at[17] ? at[18] : 1'b1,
                at[17] & at[16]};
    endfunction

    // ----------------
    // tasks
    // ----------------
    task automatic cmp_reg(input string what, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic cmp_acc(input logic [10:0] e, input logic [10:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("ERROR access result expected %h seen %h", e, g);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        reg_addr = a;
        reg_wdata = d;
        reg_be = be;
        {reg_wr, reg_rd} = 2'b10;
        if (be[0] && (a == `MRA_ADDR_SELECTOR || (a == `MRA_ADDR_BASE && d[4]))) sel_m = d[2:0];
        if (a == `MRA_ADDR_BASE) base_m[sel_m] = (base_m[sel_m] & ~m | d & m) & 32'hFFFFFFE0;
        if (a == `MRA_ADDR_ATTR) attr_m[sel_m] = (attr_m[sel_m] & ~m | d & m) & 32'h1707FF3F;
        @(negedge clk);
    endtask

    task automatic rd(input logic [31:0] a, input string what);
        logic [31:0] e;
        e = 32'h0;
        if (a == `MRA_ADDR_SELECTOR) e = sel_m;
        if (a == `MRA_ADDR_BASE) e = base_m[sel_m] & amask(sel_m) | sel_m;
        if (a == `MRA_ADDR_ATTR) e = attr_m[sel_m];
        reg_addr = a;
        {reg_wr, reg_rd} = 2'b01;
        @(negedge clk);
        cmp_reg({what, " rvalid"}, 32'h1, {31'h0, reg_rvalid});
        cmp_reg(what, e, reg_rdata);
    endtask

    task automatic test_done();
        if (failures == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ----------------
    // main sequence
    // ----------------
    initial begin
        logic [31:0] a, d;
        logic [4:0]  k;
        int unsigned sz, r2;
        void'($urandom(43723));
        {rstn, reg_wr, reg_rd, reg_addr, reg_wdata, reg_be} = '0;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        rd(`MRA_ADDR_SELECTOR, "selector");
        rd(`MRA_ADDR_ATTR, "attr");
        wr(32'hE000ED94, 32'hFFFFFFFF, 4'hF);
        rd(32'hE000ED94, "unmapped");
        for (int round = 0; round < 2; round++) begin
            for (int r = 0; r < 8; r++) begin
                // 4 GB and 32 byte regions in the second round only
                sz = (round == 1 && r < 2) ? (r == 0 ? 31 : 4) : 7 + $urandom % 24;
                d = $urandom;
                d[26:24] = r[2:0];
                d[5:1] = sz[4:0];
                d[0] = ($urandom % 4) != 0;
                a = $urandom;
                a = a & ~((32'h2 << sz) - 1) | a & 32'h0F;
                if (r % 2 == 0) begin
                    wr(`MRA_ADDR_SELECTOR, r, 4'hF);
                    wr(`MRA_ADDR_ATTR, d, 4'h3);
                    wr(`MRA_ADDR_ATTR, d, 4'hC);
                    wr(`MRA_ADDR_BASE, a, 4'hF);
                    rd(`MRA_ADDR_SELECTOR, "selector kept");
                end else begin
                    a[4:0] = {2'b10, r[2:0]};
                    wr(`MRA_ADDR_BASE, a, 4'hF);
                    rd(`MRA_ADDR_BASE, "base after retarget");
                    wr(`MRA_ADDR_ATTR, d, 4'hF);
                end
            end
            for (int r = 0; r < 8; r++) begin
                wr(`MRA_ADDR_SELECTOR, r, 4'hF);
                rd(`MRA_ADDR_SELECTOR, "selector");
                rd(`MRA_ADDR_BASE, "base");
                rd(`MRA_ADDR_ATTR, "attr");
            end
            {reg_wr, reg_rd} = 2'b00;
            repeat (200) begin
                r2 = $urandom % 8;
                a = (base_m[r2] & amask(r2)) + 32'($urandom % (64'h2 << nexp(r2)));
                k = $urandom;
                k[1] = ($urandom % 8) != 0;
                u_cpu.issue(a, k);
                cmp_acc(expect_acc(a, k), {acc_done, acc_fault, acc_miss_fault, acc_hit,
                    acc_region, acc_mem_type, acc_shareable, acc_write_back});
                if ($urandom % 4 == 0) u_cpu.idle();
            end
            u_cpu.idle();
        end
        test_done();
    end
endmodule
